// File: include/mmusc_pkg.sv
// package for the system control register bank: selectors, field positions, carriers
package mmusc_pkg;

    localparam logic [3:0] CRN_CTRL = 4'h1;
    localparam logic [3:0] CRN_TTB = 4'h2;
    localparam logic [3:0] CRN_DOMAIN = 4'h3;
    localparam logic [3:0] CRN_RSVD = 4'h4;
    localparam logic [3:0] CRN_FSR = 4'h5;
    localparam logic [3:0] CRN_FAR = 4'h6;
    localparam logic [2:0] OP2_DATA = 3'h0;
    localparam logic [2:0] OP2_PREFETCH = 3'h1;
    localparam logic [2:0] OP1_ZERO = 3'h0;
    localparam logic [3:0] CRM_ZERO = 4'h0;

    localparam int CTRL_ASYNC_BIT = 31;
    localparam int CTRL_NOTFAST_BIT = 30;
    localparam int CTRL_ROUND_ROBIN_REPLACE = 14;
    localparam int CTRL_VEC_BIT = 13;
    localparam int CTRL_ICACHE_BIT = 12;
    localparam int CTRL_ROMP_BIT = 9;
    localparam int CTRL_SYSP_BIT = 8;
    localparam int CTRL_BIG_BIT = 7;
    localparam int CTRL_DCACHE_BIT = 2;
    localparam int CTRL_ALIGN_BIT = 1;
    localparam int CTRL_MMU_BIT = 0;
    localparam logic [14:0] CTRL_HIGH_RSVD_READ = 15'h0000;
    localparam logic [1:0] CTRL_MID_RSVD_READ = 2'h0;
    localparam logic [3:0] CTRL_LOW_RSVD_READ = 4'hf;

    localparam int TTB_LSB = 14;
    localparam int TTB_W = 18;
    localparam logic [13:0] TTB_LOW_READ = 14'h0000;
    localparam int FSR_W = 8;
    localparam logic [23:0] FSR_HIGH_READ = 24'h00_0000;

    localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
    localparam logic [31:0] VEC_BASE_HIGH = 32'hffff_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    localparam logic [1:0] STRAP_DONE = 2'h3;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    localparam int VICTIM_W = 6;
    localparam logic [5:0] VICTIM_TOP = 6'h3f;
    localparam logic [5:0] LFSR_SEED = 6'h2d;

    typedef enum logic [1:0] {
        CLK_FAST_BUS = 2'b00,
        CLK_SYNC = 2'b01,
        CLK_RESERVED = 2'b10,
        CLK_ASYNC = 2'b11
    } mmusc_clkmode_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic privileged;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
        logic [31:0] wdata;
    } mmusc_xfer_s;

    typedef struct packed {
        logic dataAbort;
        logic [3:0] dataDomain;
        logic [3:0] dataType;
        logic [31:0] dataAddr;
        logic prefetchAbort;
        logic [3:0] prefetchDomain;
        logic [3:0] prefetchType;
        logic prefetchRetire;
    } mmusc_fault_s;

    typedef struct packed {
        logic asyncClockSelect;
        logic notFastBusSelect;
        logic roundRobinReplace;
        logic vectorHigh;
        logic icacheEnable;
        logic romProtect;
        logic systemProtect;
        logic bigEndian;
        logic dcacheEnable;
        logic alignCheckEnable;
        logic mmuEnable;
    } mmusc_ctrl_s;

endpackage

// File: rtl/mmusc_victim.sv
// cache victim counter stepping random or round robin within base..top
`timescale 1ns/10ps
`default_nettype none

module mmusc_victim
    import mmusc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic roundRobin,
    input wire logic linefill,
    input wire logic baseLoad,
    input wire logic [VICTIM_W-1:0] baseIn,
    output logic [VICTIM_W-1:0] victim
);

    typedef struct packed {
        logic [VICTIM_W-1:0] base;
        logic [VICTIM_W-1:0] victim;
        logic [VICTIM_W-1:0] lfsr;
    } mmusc_victim_s;

    mmusc_victim_s q, d;

    always_comb begin
        d = q;
        d.lfsr = {q.lfsr[VICTIM_W-2:0], q.lfsr[5] ^ q.lfsr[4]};
        if (baseLoad) begin
            d.base = baseIn;
            d.victim = baseIn;
        end else if (linefill) begin
            if (roundRobin) begin
                d.victim = (q.victim == VICTIM_TOP) ? q.base : q.victim + 6'h01; // RULE24
            end else begin
                d.victim = (q.lfsr < q.base) ? q.base : q.lfsr; // RULE24
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '{base: '0, victim: '0, lfsr: LFSR_SEED};
        end else begin
            q <= d;
        end
    end

    assign victim = q.victim;

endmodule

`default_nettype wire

// File: rtl/mmusc_regs.sv
// system control register bank: control, table base, domains, fault status and address
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [RULE1] control word read and written whole on register 1, selectors zero
// [RULE2] reset clears control bits; vector bit takes high-vector input level
// [RULE3] control bits 29..15 reserved, read zero here, software writes zero
// [RULE4] control bits 6..3 read ones, bits 11..10 read zeros
// [RULE5] bit 14 picks random or round-robin replacement
// [RULE6] bit 13 puts vectors at low or high base
// [RULE7] bit 12 enables instruction cache
// [RULE8] bits 9 and 8 go to the permission checker
// [RULE9] bit 7 selects little or big endian
// [RULE10] bit 2 enables data cache
// [RULE11] bit 1 enables alignment fault checks, else none raised
// [RULE12] bit 0 enables translation, else MMU bypassed
// [RULE13] bits 31..30 encode fast-bus, synchronous, reserved, asynchronous modes
// [RULE14] register 2 bits 31..14 hold table pointer, read back
// [RULE15] table base bits 13..0 undefined on read, written zero
// [RULE16] register 3 holds sixteen 2-bit domain fields, full read-write
// [RULE17] software leaves register 4 alone
// [RULE18] data abort captures domain and type; bit 8 reads zero
// [RULE19] pipelined prefetch fault status on register 5 selector 1
// [RULE20] both fault status registers writable for debug restore
// [RULE21] register 6 captures data fault address, not prefetch; writable
// [RULE22] software keeps reserved control bits at fixed values
// [RULE23] only privileged transfers reach registers; others trap undefined
// [RULE24] replacement bit steers victim counter on each linefill
// [RULE25] fault type and domain codes carried as opaque values
module mmusc_regs
    import mmusc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire mmusc_xfer_s xferReq,
    output logic respValid,
    output logic [31:0] respData,
    output logic undefTrap,
    input wire mmusc_fault_s faultIn,
    input wire logic vectorInitHighIn,
    input wire logic dataAccessValid,
    input wire logic [1:0] dataAccessSize,
    input wire logic [1:0] dataAddrLow,
    output logic alignFault,
    input wire logic linefill,
    input wire logic victimBaseLoad,
    input wire logic [VICTIM_W-1:0] victimBaseIn,
    output logic [VICTIM_W-1:0] victimIndex,
    output mmusc_ctrl_s ctrl,
    output mmusc_clkmode_e clockMode,
    output logic [31:0] vectorBase,
    output logic [TTB_W-1:0] translationTableBase,
    output logic [31:0] domainAccess,
    output logic [FSR_W-1:0] dataFaultStatus,
    output logic [FSR_W-1:0] prefetchFaultStatus,
    output logic [31:0] faultAddress
);

    typedef struct packed {
        logic vinitMeta;
        logic vinitSync;
        logic [1:0] strapCnt;
        mmusc_ctrl_s ctrl;
        logic [1:0] clockMode;
        logic [31:0] vectorBase;
        logic [TTB_W-1:0] translation_table_base;
        logic [31:0] domain;
        logic [FSR_W-1:0] dataFsr;
        logic [FSR_W-1:0] pfPending;
        logic [FSR_W-1:0] pfFsr;
        logic [31:0] fault_address;
        logic respValid;
        logic [31:0] respData;
        logic undefTrap;
        logic alignFault;
    } mmusc_state_s;

    mmusc_state_s q, d;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic selectorOk(input mmusc_xfer_s x);
        logic ok;
        ok = (x.op1 == OP1_ZERO) && (x.crm == CRM_ZERO);
        if (x.crn == CRN_FSR) begin
            ok = ok && ((x.op2 == OP2_DATA) || (x.op2 == OP2_PREFETCH)); // RULE19
        end else begin
            ok = ok && (x.op2 == OP2_DATA);
        end
        return ok;
    endfunction

    function automatic logic [31:0] packCtrl(input mmusc_ctrl_s c);
        logic [31:0] w;
        w = {c.asyncClockSelect, c.notFastBusSelect, // RULE13
             CTRL_HIGH_RSVD_READ, // RULE3
             c.roundRobinReplace, c.vectorHigh, c.icacheEnable,
             CTRL_MID_RSVD_READ, // RULE4
             c.romProtect, c.systemProtect, c.bigEndian,
             CTRL_LOW_RSVD_READ, // RULE4
             c.dcacheEnable, c.alignCheckEnable, c.mmuEnable};
        return w;
    endfunction

    function automatic mmusc_ctrl_s unpackCtrl(input logic [31:0] w);
        mmusc_ctrl_s c;
        c.asyncClockSelect = w[CTRL_ASYNC_BIT];
        c.notFastBusSelect = w[CTRL_NOTFAST_BIT];
        c.roundRobinReplace = w[CTRL_ROUND_ROBIN_REPLACE];
        c.vectorHigh = w[CTRL_VEC_BIT];
        c.icacheEnable = w[CTRL_ICACHE_BIT];
        c.romProtect = w[CTRL_ROMP_BIT];
        c.systemProtect = w[CTRL_SYSP_BIT];
        c.bigEndian = w[CTRL_BIG_BIT];
        c.dcacheEnable = w[CTRL_DCACHE_BIT];
        c.alignCheckEnable = w[CTRL_ALIGN_BIT];
        c.mmuEnable = w[CTRL_MMU_BIT];
        return c;
    endfunction

    function automatic logic [31:0] packFsr(input logic [FSR_W-1:0] f);
        return {FSR_HIGH_READ, f}; // RULE18
    endfunction

    function automatic logic misaligned(input logic [1:0] size, input logic [1:0] addr);
        logic m;
        m = 1'b0;
        if (size == SIZE_HALF) begin
            m = addr[0];
        end else if (size == SIZE_WORD) begin
            m = addr != 2'h0;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.respValid = 1'b0;
        d.undefTrap = 1'b0;
        d.respData = READ_ZERO;
        d.vinitMeta = vectorInitHighIn;
        d.vinitSync = q.vinitMeta;

        // strap capture after reset release
        if (q.strapCnt != STRAP_DONE) begin
            d.strapCnt = q.strapCnt + 2'h1;
            d.ctrl.vectorHigh = q.vinitSync; // RULE2
        end

        // coprocessor transfers
        if (xferReq.valid) begin
            d.respValid = 1'b1;
            if (!xferReq.privileged) begin
                d.undefTrap = 1'b1; // RULE23
            end else if (selectorOk(xferReq)) begin
                if (xferReq.write) begin
                    unique case (xferReq.crn)
                        CRN_CTRL: d.ctrl = unpackCtrl(xferReq.wdata); // RULE1
                        CRN_TTB: d.translation_table_base = xferReq.wdata[31:TTB_LSB]; // RULE14
                        CRN_DOMAIN: d.domain = xferReq.wdata; // RULE16
                        CRN_FSR: begin
                            if (xferReq.op2 == OP2_PREFETCH) begin
                                d.pfFsr = xferReq.wdata[FSR_W-1:0]; // RULE20
                            end else begin
                                d.dataFsr = xferReq.wdata[FSR_W-1:0]; // RULE20
                            end
                        end
                        CRN_FAR: d.fault_address = xferReq.wdata; // RULE21
                        default: begin
                        end
                    endcase
                end else begin
                    unique case (xferReq.crn)
                        CRN_CTRL: d.respData = packCtrl(q.ctrl); // RULE1
                        CRN_TTB: d.respData = {q.translation_table_base, TTB_LOW_READ}; // RULE14 RULE15
                        CRN_DOMAIN: d.respData = q.domain; // RULE16
                        CRN_FSR: begin
                            if (xferReq.op2 == OP2_PREFETCH) begin
                                d.respData = packFsr(q.pfFsr); // RULE19
                            end else begin
                                d.respData = packFsr(q.dataFsr); // RULE18
                            end
                        end
                        CRN_FAR: d.respData = q.fault_address; // RULE21
                        default: d.respData = READ_ZERO;
                    endcase
                end
            end
        end

        // fault capture overrides a debug write in the same cycle
        if (faultIn.dataAbort) begin
            d.dataFsr = {faultIn.dataDomain, faultIn.dataType}; // RULE18 RULE25
            d.fault_address = faultIn.dataAddr; // RULE21
        end
        if (faultIn.prefetchAbort) begin
            d.pfPending = {faultIn.prefetchDomain, faultIn.prefetchType}; // RULE19 RULE25
        end
        if (faultIn.prefetchRetire) begin
            d.pfFsr = faultIn.prefetchAbort ?
                {faultIn.prefetchDomain, faultIn.prefetchType} : q.pfPending; // RULE19
        end

        // derived settings
        d.clockMode = {d.ctrl.asyncClockSelect, d.ctrl.notFastBusSelect}; // RULE13
        d.vectorBase = d.ctrl.vectorHigh ? VEC_BASE_HIGH : VEC_BASE_LOW; // RULE6
        d.alignFault = dataAccessValid && q.ctrl.alignCheckEnable
            && misaligned(dataAccessSize, dataAddrLow); // RULE11
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0; // RULE2
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // victim counter

    mmusc_victim u_victim (
        .clk(clk),
        .resetn(resetn),
        .roundRobin(q.ctrl.roundRobinReplace), // RULE5 RULE24
        .linefill(linefill),
        .baseLoad(victimBaseLoad),
        .baseIn(victimBaseIn),
        .victim(victimIndex)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign respValid = q.respValid;
    assign respData = q.respData;
    assign undefTrap = q.undefTrap;
    assign alignFault = q.alignFault;
    assign ctrl = q.ctrl; // RULE7 RULE8 RULE9 RULE10 RULE12
    assign clockMode = mmusc_clkmode_e'(q.clockMode);
    assign vectorBase = q.vectorBase;
    assign translationTableBase = q.translation_table_base;
    assign domainAccess = q.domain;
    assign dataFaultStatus = q.dataFsr;
    assign prefetchFaultStatus = q.pfFsr;
    assign faultAddress = q.fault_address;

endmodule

`default_nettype wire

// File: tb/mmusc_sva.sv
// assertions on the ports of the system control register bank
`timescale 1ns/10ps
`default_nettype none
module mmusc_sva
    import mmusc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire mmusc_xfer_s xferReq,
    input wire logic respValid,
    input wire logic [31:0] respData,
    input wire logic undefTrap,
    input wire mmusc_fault_s faultIn,
    input wire logic dataAccessValid,
    input wire logic [1:0] dataAccessSize,
    input wire logic [1:0] dataAddrLow,
    input wire logic alignFault,
    input wire mmusc_ctrl_s ctrl,
    input wire mmusc_clkmode_e clockMode,
    input wire logic [31:0] vectorBase,
    input wire logic [TTB_W-1:0] translationTableBase,
    input wire logic [31:0] domainAccess,
    input wire logic [FSR_W-1:0] dataFaultStatus,
    input wire logic [31:0] faultAddress
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic misal;
    assign misal = dataAccessValid && ((dataAccessSize == SIZE_HALF && dataAddrLow[0])
        || (dataAccessSize == SIZE_WORD && dataAddrLow != 2'h0));
    ////////////////////////////////////////////////////////////
    sequence s_acc(logic w, logic [3:0] n);
        xferReq.valid && xferReq.privileged && xferReq.write == w && xferReq.crn == n
            && xferReq.op1 == OP1_ZERO && xferReq.crm == CRM_ZERO && xferReq.op2 == OP2_DATA;
    endsequence
    property p_resp; xferReq.valid |=> respValid; endproperty
    property p_trap;
        xferReq.valid && !xferReq.privileged |=> undefTrap && respData == READ_ZERO
            && $stable(domainAccess);
    endproperty
    property p_ctrlRd;
        s_acc(1'b0, CRN_CTRL) |=> respData[6:3] == CTRL_LOW_RSVD_READ
            && respData[11:10] == CTRL_MID_RSVD_READ && respData[13] == ctrl.vectorHigh;
    endproperty
    property p_ctrlWr;
        s_acc(1'b1, CRN_CTRL) |=> clockMode == $past(xferReq.wdata[31:30])
            && ctrl.roundRobinReplace == $past(xferReq.wdata[14])
            && ctrl.mmuEnable == $past(xferReq.wdata[0]);
    endproperty
    property p_vec; vectorBase == (ctrl.vectorHigh ? VEC_BASE_HIGH : VEC_BASE_LOW); endproperty
    property p_ttb;
        s_acc(1'b1, CRN_TTB) |=> translationTableBase == $past(xferReq.wdata[31:14]);
    endproperty
    property p_dom; s_acc(1'b1, CRN_DOMAIN) |=> domainAccess == $past(xferReq.wdata); endproperty
    property p_dfsr;
        faultIn.dataAbort |=> dataFaultStatus[7:4] == $past(faultIn.dataDomain)
            && dataFaultStatus[3:0] == $past(faultIn.dataType)
            && faultAddress == $past(faultIn.dataAddr);
    endproperty
    property p_far;
        faultIn.prefetchAbort && !faultIn.dataAbort && !xferReq.valid |=> $stable(faultAddress);
    endproperty
    property p_align; misal |=> alignFault == $past(ctrl.alignCheckEnable); endproperty
    ////////////////////////////////////////////////////////////
    a_resp: assert property (p_resp) else $error("transfer not answered");
    a_trap: assert property (p_trap) else $error("unprivileged transfer not trapped");
    a_ctrlRd: assert property (p_ctrlRd) else $error("control read fields wrong");
    a_ctrlWr: assert property (p_ctrlWr) else $error("control write not applied");
    a_vec: assert property (p_vec) else $error("vector base wrong");
    a_ttb: assert property (p_ttb) else $error("table base not loaded");
    a_dom: assert property (p_dom) else $error("domain word not loaded");
    a_dfsr: assert property (p_dfsr) else $error("data fault not captured");
    a_far: assert property (p_far) else $error("fault address moved on prefetch");
    a_align: assert property (p_align) else $error("alignment fault wrong");
endmodule
bind mmusc_regs mmusc_sva u_sva (.clk(clk), .resetn(resetn), .xferReq(xferReq),
    .respValid(respValid), .respData(respData), .undefTrap(undefTrap), .faultIn(faultIn),
    .dataAccessValid(dataAccessValid), .dataAccessSize(dataAccessSize),
    .dataAddrLow(dataAddrLow), .alignFault(alignFault), .ctrl(ctrl), .clockMode(clockMode),
    .vectorBase(vectorBase), .translationTableBase(translationTableBase),
    .domainAccess(domainAccess), .dataFaultStatus(dataFaultStatus),
    .faultAddress(faultAddress));
`default_nettype wire

// File: tb/mmusc_core.sv
// core model issuing coprocessor register transfers
`timescale 1ns/10ps
`default_nettype none
module mmusc_core
    import mmusc_pkg::*;
(
    input wire logic clk,
    input wire logic respValid,
    input wire logic [31:0] respData,
    input wire logic undefTrap,
    output var mmusc_xfer_s xferReq
);
    initial xferReq = '0;
    // request held to the taking edge, answer sampled half a cycle later
    task automatic xfer(input logic w, input logic p, input logic [3:0] n,
        input logic [2:0] o, input logic [31:0] wd, output logic [31:0] rd,
        output logic tr, output logic ok);
        @(negedge clk);
        xferReq = {1'b1, w, p, OP1_ZERO, n, CRM_ZERO, o, wd};
        @(negedge clk);
        rd = respData;
        tr = undefTrap;
        ok = respValid;
        xferReq.valid = 1'b0;
        xferReq.wdata = ~wd;
    endtask
endmodule
`default_nettype wire

// File: tb/mmusc_regs_test.sv
// self-checking bench for the system control register bank
`timescale 1ns/10ps
`default_nettype none
module mmusc_regs_test import mmusc_pkg::*;;
    logic clk = 1'b0, resetn = 1'b0, vectorInitHighIn = 1'b1;
    logic dataAccessValid = 1'b0, linefill = 1'b0, victimBaseLoad = 1'b0;
    logic [1:0] dataAccessSize = 2'h0, dataAddrLow = 2'h0;
    logic [5:0] victimBaseIn = 6'h00, victimIndex;
    mmusc_xfer_s xferReq;
    mmusc_fault_s faultIn = '0;
    mmusc_ctrl_s ctrl;
    mmusc_clkmode_e clockMode;
    logic respValid, undefTrap, alignFault, t, v;
    logic [31:0] respData, vectorBase, domainAccess, faultAddress, d;
    logic [TTB_W-1:0] translationTableBase;
    logic [FSR_W-1:0] dataFaultStatus, prefetchFaultStatus;
    int bad_count = 0, num_checks = 0, cyc = 0;
    int pos[11] = '{31, 30, 14, 13, 12, 9, 8, 7, 2, 1, 0};
    logic [1:0] sz[6] = '{SIZE_HALF, SIZE_WORD, SIZE_HALF, SIZE_BYTE, SIZE_HALF, SIZE_WORD};
    logic [1:0] al[6] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h1, 2'h3};
    logic [5:0] exv = 6'b00_0011;
    always #5 clk = ~clk;
    mmusc_regs DUT (.clk(clk), .resetn(resetn), .xferReq(xferReq), .respValid(respValid),
        .respData(respData), .undefTrap(undefTrap), .faultIn(faultIn),
        .vectorInitHighIn(vectorInitHighIn), .dataAccessValid(dataAccessValid),
        .dataAccessSize(dataAccessSize), .dataAddrLow(dataAddrLow), .alignFault(alignFault),
        .linefill(linefill), .victimBaseLoad(victimBaseLoad), .victimBaseIn(victimBaseIn),
        .victimIndex(victimIndex), .ctrl(ctrl), .clockMode(clockMode),
        .vectorBase(vectorBase), .translationTableBase(translationTableBase),
        .domainAccess(domainAccess), .dataFaultStatus(dataFaultStatus),
        .prefetchFaultStatus(prefetchFaultStatus), .faultAddress(faultAddress));
    mmusc_core core (.clk(clk), .respValid(respValid), .respData(respData),
        .undefTrap(undefTrap), .xferReq(xferReq));
    ////////////////////////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task rd(input logic [3:0] n, input logic [2:0] o, input logic [31:0] e);
        core.xfer(1'b0, 1'b1, n, o, 32'h0000_0000, d, t, v);
        chk({30'h0, v, t}, 32'h0000_0002);
        chk(d, e);
    endtask
    task wr(input logic [3:0] n, input logic [2:0] o, input logic [31:0] w);
        core.xfer(1'b1, 1'b1, n, o, w, d, t, v);
        chk({30'h0, v, t}, 32'h0000_0002);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            bad_count++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        rd(CRN_CTRL, OP2_DATA, 32'h0000_2078);
        chk(vectorBase, VEC_BASE_HIGH);
        rd(CRN_TTB, OP2_DATA, 32'h0000_0000);
        $display("test reset done");
        wr(CRN_CTRL, OP2_DATA, 32'hc000_73ff);
        rd(CRN_CTRL, OP2_DATA, 32'hc000_73ff);
        for (int i = 0; i < 11; i++) begin
            wr(CRN_CTRL, OP2_DATA, 32'h0000_0078 | (32'h1 << pos[i]));
            rd(CRN_CTRL, OP2_DATA, 32'h0000_0078 | (32'h1 << pos[i]));
            chk({21'h0, ctrl}, 32'h1 << (10 - i));
        end
        for (int m = 0; m < 4; m++) begin
            wr(CRN_CTRL, OP2_DATA, {m[1:0], 30'h0000_0078});
            chk({30'h0, clockMode}, m);
            chk(vectorBase, VEC_BASE_LOW);
        end
        $display("test control done");
        wr(CRN_TTB, OP2_DATA, 32'ha5a5_4000);
        rd(CRN_TTB, OP2_DATA, 32'ha5a5_4000);
        chk({14'h0, translationTableBase}, 32'h0002_9695);
        wr(CRN_DOMAIN, OP2_DATA, 32'h1b6c_e4a9);
        rd(CRN_DOMAIN, OP2_DATA, 32'h1b6c_e4a9);
        chk(domainAccess, 32'h1b6c_e4a9);
        core.xfer(1'b1, 1'b0, CRN_DOMAIN, OP2_DATA, 32'h0000_0000, d, t, v);
        chk({30'h0, v, t}, 32'h0000_0003);
        rd(CRN_DOMAIN, OP2_DATA, 32'h1b6c_e4a9);
        rd(CRN_CTRL, OP2_PREFETCH, READ_ZERO);
        wr(CRN_DOMAIN, OP2_PREFETCH, 32'h0000_0000);
        rd(CRN_DOMAIN, OP2_DATA, 32'h1b6c_e4a9);
        $display("test table and domain done");
        @(negedge clk);
        faultIn.dataAbort = 1'b1;
        faultIn.dataDomain = 4'h3;
        faultIn.dataType = 4'h5;
        faultIn.dataAddr = 32'h1234_5678;
        @(negedge clk);
        faultIn.dataAbort = 1'b0;
        faultIn.dataAddr = 32'hedcb_a987;
        faultIn.prefetchAbort = 1'b1;
        faultIn.prefetchDomain = 4'hc;
        faultIn.prefetchType = 4'h9;
        chk({24'h0, dataFaultStatus}, 32'h0000_0035);
        chk(faultAddress, 32'h1234_5678);
        @(negedge clk);
        faultIn.prefetchAbort = 1'b0;
        faultIn.prefetchRetire = 1'b1;
        @(negedge clk);
        faultIn.prefetchRetire = 1'b0;
        chk({24'h0, prefetchFaultStatus}, 32'h0000_00c9);
        rd(CRN_FSR, OP2_PREFETCH, 32'h0000_00c9);
        rd(CRN_FSR, OP2_DATA, 32'h0000_0035);
        rd(CRN_FAR, OP2_DATA, 32'h1234_5678);
        wr(CRN_FSR, OP2_DATA, 32'h0000_00a7);
        rd(CRN_FSR, OP2_DATA, 32'h0000_00a7);
        wr(CRN_FSR, OP2_PREFETCH, 32'h0000_005e);
        rd(CRN_FSR, OP2_PREFETCH, 32'h0000_005e);
        wr(CRN_FAR, OP2_DATA, 32'h0bad_f00d);
        rd(CRN_FAR, OP2_DATA, 32'h0bad_f00d);
        $display("test faults done");
        wr(CRN_CTRL, OP2_DATA, 32'h0000_007a);
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            dataAccessValid = 1'b1;
            dataAccessSize = sz[k];
            dataAddrLow = al[k];
            @(negedge clk);
            dataAccessValid = 1'b0;
            chk({31'h0, alignFault}, {31'h0, exv[k]});
            if (k == 3) wr(CRN_CTRL, OP2_DATA, 32'h0000_0078);
        end
        $display("test alignment done");
        wr(CRN_CTRL, OP2_DATA, 32'h0000_4078);
        @(negedge clk);
        victimBaseLoad = 1'b1;
        victimBaseIn = 6'h3e;
        @(negedge clk);
        victimBaseLoad = 1'b0;
        chk({26'h0, victimIndex}, 32'h0000_003e);
        for (int j = 0; j < 2; j++) begin
            @(negedge clk);
            linefill = 1'b1;
            @(negedge clk);
            linefill = 1'b0;
            chk({26'h0, victimIndex}, (j == 0) ? 32'h0000_003f : 32'h0000_003e);
        end
        wr(CRN_CTRL, OP2_DATA, 32'h0000_0078);
        @(negedge clk);
        victimBaseLoad = 1'b1;
        victimBaseIn = 6'h20;
        @(negedge clk);
        victimBaseLoad = 1'b0;
        linefill = 1'b1;
        @(negedge clk);
        linefill = 1'b0;
        chk({31'h0, victimIndex >= 6'h20}, 32'h0000_0001);
        $display("test victim done");
        @(negedge clk);
        vectorInitHighIn = 1'b0;
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        rd(CRN_CTRL, OP2_DATA, 32'h0000_0078);
        chk(vectorBase, VEC_BASE_LOW);
        chk(domainAccess, READ_ZERO);
        chk({24'h0, dataFaultStatus}, READ_ZERO);
        $display("test second reset done");
        test_done();
    end
endmodule
`default_nettype wire
